//--- hdl/isc_device.sv
// Device end: decodes indexer commands and launches moves.
// Assumes the motion generator reports progress on its user-side ports.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module isc_device #(
   parameter int TQ_DELAY_CYC_MAX = 65535
) (
   // Clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      nrst_in,
   // Configuration
   input  wire logic                      two_stations_in,
   input  wire logic                      indexer_enable_param_in,
   input  wire logic [3:0]                speed_source_param_in,
   input  wire logic [7:0]                station_count_param_in,
   input  wire logic                      station_numbering_dir_param_in,
   input  wire logic [isc_pkg::DELAY_W-1:0] torque_limit_delay_param_in,
   input  wire logic [isc_pkg::TQ_W-1:0]  alt_torque_limit_param_in,
   input  wire logic [isc_pkg::TQ_W-1:0]  base_torque_limit_in,
   // Motion generator status
   input  wire logic                      home_done_in,
   input  wire logic                      motion_busy_in,
   input  wire logic                      in_band_in,
   input  wire logic [7:0]                current_station_in,
   // Link
   isc_if.dev                             link,
   // Motion generator command
   output logic                           move_req_out,
   output logic [7:0]                     move_station_out,
   output logic [3:0]                     move_profile_out,
   output logic                           move_direct_speed_out,
   output logic [isc_pkg::SPEED_W-1:0]    move_speed_out,
   output logic                           move_ccw_out,
   output logic [isc_pkg::TQ_W-1:0]       torque_limit_out
);
   import isc_pkg::*;

   isc_state_t          state;
   logic                start_q;
   logic                start_rise;
   logic                mode_ok;
   logic [7:0]          sel_station;
   logic [3:0]          sel_profile;
   logic                sel_direct;
   logic [7:0]          fwd_dist;
   logic [7:0]          bwd_dist;
   logic [7:0]          count_m1;
   logic                inpos;
   logic [DELAY_W-1:0]  tq_cnt;
   logic                tq_alt;
   logic                sel_over;
   logic [DELAY_W-1:0]  tq_limit;

   assign start_rise = link.move_launch_cmd & ~start_q;
   assign mode_ok    = indexer_enable_param_in & (link.op_mode_sel == MODE_AUTO2);
   assign count_m1   = station_count_param_in - 8'h01;

   // Station and profile decode
   always_comb begin
      // Word numbers above eight bits must warn, not wrap onto a low station
      sel_over    = link.word_command_method_sel
                    & (link.target_station_word[15:8] != 8'h00);
      if (link.word_command_method_sel) begin
         sel_station = link.target_station_word[7:0];
      end else if (two_stations_in) begin
         sel_station = link.station_sel;
      end else begin
         sel_station = {3'h0, link.station_sel[4:0]};
      end
      sel_direct = link.word_command_method_sel & two_stations_in
                   & (speed_source_param_in == SPEED_SRC_WORD);
      if (sel_direct || !two_stations_in) begin
         sel_profile = PROFILE_DEFAULT;
      end else if (link.word_command_method_sel) begin
         sel_profile = link.table_or_speed_word[3:0];
      end else begin
         sel_profile = {1'b0, link.profile_sel} + 4'h1;
      end
   end

   // Shortest direction; numbering direction parameter unused in this mode
   // Equal distances keep the forward direction
   always_comb begin
      fwd_dist = sel_station - current_station_in;
      if (sel_station < current_station_in) begin
         fwd_dist = station_count_param_in - current_station_in + sel_station;
      end
      bwd_dist = station_count_param_in - fwd_dist;
      if (fwd_dist == 8'h00) begin
         bwd_dist = 8'h00;
      end
   end

   // Reset level matches the idle command level, so no false edge after reset;
   // a start already high when reset ends is taken once
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         start_q <= 1'b0;
      end else begin
         start_q <= link.move_launch_cmd;
      end
   end

   // Move sequencer
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state                      <= ISC_IDLE;
         move_req_out               <= 1'b0;
         move_station_out           <= 8'h00;
         move_profile_out           <= PROFILE_DEFAULT;
         move_direct_speed_out      <= 1'b0;
         move_speed_out             <= '0;
         move_ccw_out               <= 1'b0;
         link.move_done_flag        <= 1'b0;
         link.home_incomplete_alarm <= 1'b0;
         link.station_range_warning <= 1'b0;
      end else begin
         move_req_out <= 1'b0;
         case (state)
            ISC_IDLE, ISC_DONE: begin
               if (start_rise && mode_ok) begin
                  if (!home_done_in) begin
                     link.home_incomplete_alarm <= 1'b1;
                  end else if (sel_over || (sel_station > count_m1)) begin
                     link.station_range_warning <= 1'b1;
                  end else begin
                     link.home_incomplete_alarm <= 1'b0;
                     link.station_range_warning <= 1'b0;
                     move_req_out          <= 1'b1;
                     move_station_out      <= sel_station;
                     move_profile_out      <= sel_profile;
                     move_direct_speed_out <= sel_direct;
                     move_speed_out        <= link.table_or_speed_word;
                     move_ccw_out          <= (bwd_dist < fwd_dist);
                     link.move_done_flag   <= 1'b0;
                     state                 <= ISC_MOVE;
                  end
               end
            end
            ISC_MOVE: begin
               // Wait one cycle so busy from the generator can rise
               if (!move_req_out && !motion_busy_in) begin
                  link.move_done_flag <= 1'b1;
                  state               <= ISC_DONE;
               end
            end
            default: state <= ISC_IDLE;
         endcase
      end
   end

   // In-position also valid after power-up when parked in a band
   assign inpos = in_band_in & !motion_busy_in & (state != ISC_MOVE);

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.in_position_flag <= 1'b0;
      end else begin
         link.in_position_flag <= inpos;
      end
   end

   // Setting clamped so an oversized delay still ends in a switch-over
   assign tq_limit = (32'(torque_limit_delay_param_in) > TQ_DELAY_CYC_MAX)
                     ? DELAY_W'(TQ_DELAY_CYC_MAX) : torque_limit_delay_param_in;

   // Torque limit switch-over after a delay in cycles
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tq_cnt           <= '0;
         tq_alt           <= 1'b0;
         torque_limit_out <= '0;
      end else begin
         if (!link.in_position_flag) begin
            tq_cnt <= '0;
            tq_alt <= 1'b0;
         end else if (tq_cnt >= tq_limit) begin
            tq_alt <= 1'b1;
         end else begin
            tq_cnt <= tq_cnt + 1'b1;
         end
         torque_limit_out <= tq_alt ? alt_torque_limit_param_in : base_torque_limit_in;
      end
   end
endmodule
`default_nettype wire

//--- hdl/isc_pkg.sv
// Package for the shortest-rotation indexer command block.
// Assumes a single 200 MHz clock shared by both ends.
package isc_pkg;
   localparam int          CLK_MHZ            = 200;
   localparam int          STATION_W          = 8;
   localparam int          PROFILE_W          = 3;
   localparam int          SPEED_W            = 16;
   localparam int          POS_W              = 32;
   localparam int          TQ_W               = 16;
   localparam int          DELAY_W            = 16;
   localparam logic [7:0]  MAX_STATION        = 8'hFE;
   localparam logic [3:0]  PROFILE_DEFAULT    = 4'h1;
   localparam logic [3:0]  SPEED_SRC_TABLE    = 4'h0;
   localparam logic [3:0]  SPEED_SRC_WORD     = 4'h1;
   localparam logic [1:0]  MODE_AUTO2         = 2'h3;
   localparam logic [7:0]  STATION_COUNT_RST  = 8'h08;
   // Torque delay counts in clock cycles
   localparam int          MS_NS              = 1000000;
   localparam int          CLK_PERIOD_NS      = 5;
   localparam int          CYC_PER_MS         = MS_NS / CLK_PERIOD_NS;
   // Controller register offsets (byte addresses)
   localparam logic [3:0]  REG_CTRL           = 4'h0;
   localparam logic [3:0]  REG_SEL            = 4'h4;
   localparam logic [3:0]  REG_WORDS          = 4'h8;
   localparam logic [3:0]  REG_STATUS         = 4'hC;
   typedef enum logic [1:0] {
      ISC_IDLE = 2'b00,
      ISC_MOVE = 2'b01,
      ISC_DONE = 2'b10
   } isc_state_t;
endpackage

//--- hdl/isc_if.sv
// Link between the indexer device end and the fieldbus controller end.
// Plain bits and words, all synchronous to one clock.
`timescale 1ns/10ps
`default_nettype none
interface isc_if;
   import isc_pkg::*;
   logic                 move_launch_cmd;
   logic [1:0]           op_mode_sel;
   logic [7:0]           station_sel;
   logic [2:0]           profile_sel;
   logic                 word_command_method_sel;
   logic [15:0]          target_station_word;
   logic [15:0]          table_or_speed_word;
   logic                 move_done_flag;
   logic                 in_position_flag;
   logic                 home_incomplete_alarm;
   logic                 station_range_warning;
   modport dev (input move_launch_cmd, op_mode_sel, station_sel, profile_sel,
                word_command_method_sel, target_station_word, table_or_speed_word,
                output move_done_flag, in_position_flag, home_incomplete_alarm,
                station_range_warning);
   modport ctl (output move_launch_cmd, op_mode_sel, station_sel, profile_sel,
                word_command_method_sel, target_station_word, table_or_speed_word,
                input move_done_flag, in_position_flag, home_incomplete_alarm,
                station_range_warning);
endinterface
`default_nettype wire

//--- hdl/isc_controller.sv
// Controller end: fieldbus master side driving the indexer bits.
// Software reaches it over Avalon-MM with waitrequest.
`timescale 1ns/10ps
`default_nettype none
module isc_controller (
   // Clock and reset
   input  wire logic          clk_in,
   input  wire logic          nrst_in,
   // Avalon-MM slave
   input  wire logic [3:0]    avs_address_in,
   input  wire logic          avs_read_in,
   input  wire logic          avs_write_in,
   input  wire logic [31:0]   avs_writedata_in,
   output logic [31:0]        avs_readdata_out,
   output logic               avs_waitrequest_out,
   // Link
   isc_if.ctl                 link
);
   import isc_pkg::*;

   logic          launch_pend;
   logic          ack;
   logic          take_wr;

   // One-cycle wait so every answer comes at the second edge
   assign ack = (avs_read_in | avs_write_in) & avs_waitrequest_out;
   // Writes land on the edge where the master sees waitrequest low
   assign take_wr = avs_write_in & ~avs_waitrequest_out;

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         avs_waitrequest_out <= 1'b1;
      end else begin
         avs_waitrequest_out <= ~ack;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         link.op_mode_sel             <= 2'h0;
         link.word_command_method_sel <= 1'b0;
         link.station_sel             <= 8'h00;
         link.profile_sel             <= 3'h0;
         link.target_station_word     <= 16'h0000;
         link.table_or_speed_word     <= 16'h0000;
      end else if (take_wr) begin
         case (avs_address_in)
            REG_CTRL: begin
               link.op_mode_sel             <= avs_writedata_in[1:0];
               link.word_command_method_sel <= avs_writedata_in[2];
            end
            REG_SEL: begin
               link.station_sel <= avs_writedata_in[7:0];
               link.profile_sel <= avs_writedata_in[10:8];
            end
            REG_WORDS: begin
               link.target_station_word <= avs_writedata_in[15:0];
               link.table_or_speed_word <= avs_writedata_in[31:16];
            end
            default: ;
         endcase
      end
   end

   // Launch request becomes a one-cycle command pulse without waiting for any earlier move
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         launch_pend          <= 1'b0;
         link.move_launch_cmd <= 1'b0;
      end else begin
         if (take_wr && avs_address_in == REG_CTRL && avs_writedata_in[8]) begin
            launch_pend <= 1'b1;
         end else if (link.move_launch_cmd) begin
            launch_pend <= 1'b0;
         end
         if (link.move_launch_cmd) begin
            link.move_launch_cmd <= 1'b0;
         end else if (launch_pend && !link.move_launch_cmd) begin
            link.move_launch_cmd <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         avs_readdata_out <= 32'h00000000;
      end else if (ack && avs_read_in) begin
         case (avs_address_in)
            REG_CTRL:   avs_readdata_out <= {23'h0, launch_pend, 5'h0,
                                             link.word_command_method_sel, link.op_mode_sel};
            REG_SEL:    avs_readdata_out <= {21'h0, link.profile_sel, link.station_sel};
            REG_WORDS:  avs_readdata_out <= {link.table_or_speed_word,
                                             link.target_station_word};
            REG_STATUS: avs_readdata_out <= {28'h0, link.station_range_warning,
                                             link.home_incomplete_alarm,
                                             link.in_position_flag, link.move_done_flag};
            default:    avs_readdata_out <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

//--- verif/isc_asserts.sv
// Checker on the link joining the controller end and the device end.
// Instantiated by the bench beside the link; sees only link wires.
`timescale 1ns/10ps
`default_nettype none
module isc_asserts #(
   // Lowest station count the bench uses; a masked station is never larger
   parameter int MIN_COUNT = 8
) (
   input wire logic        clk_in,
   input wire logic        nrst_in,
   input wire logic        move_launch_cmd,
   input wire logic [1:0]  op_mode_sel,
   input wire logic [7:0]  station_sel,
   input wire logic        word_command_method_sel,
   input wire logic [15:0] target_station_word,
   input wire logic        move_done_flag,
   input wire logic        home_incomplete_alarm,
   input wire logic        station_range_warning
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   AST_CMD_PULSE: assert property ($rose(move_launch_cmd) |=> !move_launch_cmd)
      else $error("launch command held over one cycle");
   AST_DONE_ON_EDGE: assert property ($fell(move_done_flag) |->
      $past(move_launch_cmd) && !$past(move_launch_cmd, 2))
      else $error("move began without a launch edge");
   AST_MODE_GATE: assert property ($rose(move_launch_cmd) &&
      op_mode_sel != isc_pkg::MODE_AUTO2 |=> !$fell(move_done_flag))
      else $error("move began outside the indexer mode");
   AST_HOME_CAUSE: assert property ($changed(home_incomplete_alarm) |->
      $past(move_launch_cmd))
      else $error("home alarm changed without a launch");
   AST_ALARM_NO_MOVE: assert property ($rose(home_incomplete_alarm) |->
      !$fell(move_done_flag))
      else $error("move began despite home alarm");
   AST_WARN_CAUSE: assert property ($changed(station_range_warning) |->
      $past(move_launch_cmd))
      else $error("range warning changed without a launch");
   AST_WARN_RANGE: assert property ($rose(station_range_warning) |->
      ($past(word_command_method_sel) ? $past(target_station_word)
       : 16'($past(station_sel))) >= MIN_COUNT)
      else $error("range warning for a station in range");
   AST_BUSY_STABLE: assert property ($fell(move_done_flag) |=>
      ($stable(home_incomplete_alarm) && $stable(station_range_warning))
      until move_done_flag)
      else $error("flags moved during a running move");
   AST_DONE_BOUND: assert property ($fell(move_done_flag) |-> ##[1:200] move_done_flag)
      else $error("move never completed");
   COV_MOVE: cover property ($fell(move_done_flag));
   COV_ALARM: cover property ($rose(home_incomplete_alarm));
   COV_WARN: cover property ($rose(station_range_warning));
endmodule
`default_nettype wire

//--- verif/tb.sv
// Bench: controller and device face each other over the link.
// Software side over Avalon-MM; motion generator status driven by hand.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
   $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module tb;
   import isc_pkg::*;
   typedef struct {
      logic        m, dir, ccw;
      logic [31:0] sel, wd;
      logic [7:0]  cur, st;
      logic [3:0]  src, pf;
   } isc_row_t;
   // Method, dir, ccw, SEL, WORDS, current, station, speed source, profile
   isc_row_t rows [10] = '{
      '{1'h0, 1'h0, 1'h0, 32'h001, 32'h0, 8'h00, 8'h01, 4'h0, 4'h1},
      '{1'h0, 1'h0, 1'h1, 32'h1FE, 32'h0, 8'h00, 8'hFE, 4'h0, 4'h2},
      '{1'h0, 1'h0, 1'h1, 32'h2A5, 32'h0, 8'h10, 8'hA5, 4'h0, 4'h3},
      '{1'h0, 1'h0, 1'h0, 32'h35A, 32'h0, 8'h50, 8'h5A, 4'h0, 4'h4},
      '{1'h0, 1'h0, 1'h1, 32'h480, 32'h0, 8'h00, 8'h80, 4'h0, 4'h5},
      '{1'h0, 1'h0, 1'h0, 32'h57F, 32'h0, 8'h00, 8'h7F, 4'h0, 4'h6},
      '{1'h0, 1'h0, 1'h0, 32'h602, 32'h0, 8'hFD, 8'h02, 4'h0, 4'h7},
      '{1'h0, 1'h0, 1'h1, 32'h733, 32'h0, 8'h40, 8'h33, 4'h0, 4'h8},
      '{1'h1, 1'h0, 1'h1, 32'h0, 32'h0002_0003, 8'h05, 8'h03, 4'h0, 4'h2},
      '{1'h1, 1'h1, 1'h0, 32'h0, 32'h1234_0010, 8'h0C, 8'h10, 4'h1, 4'h1}};
   logic        clk_in, nrst_in, rd, wr, two_st, idx_en, num_dir, home_ok, busy, in_band;
   logic [3:0]  addr, spd_src;
   logic [31:0] wdat, rdat;
   logic [7:0]  st_cnt, cur_st, mst;
   logic [15:0] tq_dly, mspd, tq;
   logic [3:0]  mpf;
   logic        wait_req, req, mdir, mccw;
   int          bad_count = 0, tests_run = 0, req_cnt = 0, cycles = 0;
   isc_if isc_if_inst ();
   isc_controller isc_controller_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wait_req), .link(isc_if_inst));
   isc_device isc_device_inst (.clk_in(clk_in), .nrst_in(nrst_in), .two_stations_in(two_st),
      .indexer_enable_param_in(idx_en), .speed_source_param_in(spd_src),
      .station_count_param_in(st_cnt), .station_numbering_dir_param_in(num_dir),
      .torque_limit_delay_param_in(tq_dly), .alt_torque_limit_param_in(16'hBEEF),
      .base_torque_limit_in(16'h1111), .home_done_in(home_ok), .motion_busy_in(busy),
      .in_band_in(in_band), .current_station_in(cur_st), .link(isc_if_inst),
      .move_req_out(req), .move_station_out(mst), .move_profile_out(mpf),
      .move_direct_speed_out(mdir), .move_speed_out(mspd), .move_ccw_out(mccw),
      .torque_limit_out(tq));
   isc_asserts #(.MIN_COUNT(8)) isc_asserts_inst (.clk_in(clk_in), .nrst_in(nrst_in),
      .move_launch_cmd(isc_if_inst.move_launch_cmd), .op_mode_sel(isc_if_inst.op_mode_sel),
      .station_sel(isc_if_inst.station_sel), .target_station_word(isc_if_inst.target_station_word),
      .word_command_method_sel(isc_if_inst.word_command_method_sel),
      .move_done_flag(isc_if_inst.move_done_flag),
      .home_incomplete_alarm(isc_if_inst.home_incomplete_alarm),
      .station_range_warning(isc_if_inst.station_range_warning));
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cycles++;
      if (req === 1'b1) req_cnt++;
      if (cycles == 20000) begin
         bad_count++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Holds the request until waitrequest is sampled low, then releases
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      addr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk_in);
      end while (wait_req !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_in);
      `CHK("bus idle", 1'b1, wait_req)
   endtask
   task automatic launch(input logic [1:0] md, input logic m, output int n);
      logic [31:0] q;
      n = req_cnt;
      bus(1'b1, REG_CTRL, {23'h0, 1'b1, 5'h0, m, md}, q);
      repeat (10) @(posedge clk_in);
      n = req_cnt - n;
   endtask
   task automatic finish();
      busy <= 1'b0;
      for (int k = 0; k < 20 && isc_if_inst.move_done_flag !== 1'b1; k++) @(posedge clk_in);
      `CHK("move done", 1'b1, isc_if_inst.move_done_flag)
   endtask
   initial begin
      logic [31:0] q;
      int n;
      {rd, wr, addr, wdat, num_dir, busy, cur_st, spd_src} = '0;
      {two_st, idx_en, home_ok, in_band, nrst_in} = 5'h1E;
      st_cnt = 8'hFF;
      tq_dly = 16'h0014;
      repeat (20) @(posedge clk_in);
      `CHK("reset profile", 4'h1, mpf)
      nrst_in <= 1'b1;
      for (int k = 0; k < 10 && isc_if_inst.in_position_flag !== 1'b1; k++) @(posedge clk_in);
      `CHK("in position", 1'b1, isc_if_inst.in_position_flag)
      `CHK("torque early", 16'h1111, tq)
      repeat (30) @(posedge clk_in);
      `CHK("torque late", 16'hBEEF, tq)
      bus(1'b0, 4'h2, 32'h0, q);
      `CHK("unmapped", 32'h0, q)
      foreach (rows[i]) begin
         spd_src <= rows[i].src;
         cur_st <= rows[i].cur;
         num_dir <= i[0];
         busy <= 1'b1;
         bus(1'b1, REG_SEL, rows[i].sel, q);
         bus(1'b1, REG_WORDS, rows[i].wd, q);
         launch(MODE_AUTO2, rows[i].m, n);
         `CHK("requests", 1, n)
         `CHK("station", rows[i].st, mst)
         `CHK("profile", rows[i].pf, mpf)
         `CHK("direct", rows[i].dir, mdir)
         `CHK("speed", rows[i].wd[31:16], mspd)
         `CHK("rotation", rows[i].ccw, mccw)
         finish();
      end
      busy <= 1'b1;
      bus(1'b1, REG_SEL, 32'h105, q);
      launch(MODE_AUTO2, 1'b0, n);
      bus(1'b1, REG_SEL, 32'h605, q);
      launch(MODE_AUTO2, 1'b0, n);
      `CHK("ignored start", 0, n)
      `CHK("held profile", 4'h2, mpf)
      finish();
      st_cnt <= 8'h08;
      bus(1'b1, REG_SEL, 32'h8, q);
      launch(MODE_AUTO2, 1'b0, n);
      bus(1'b0, REG_STATUS, 32'h0, q);
      `CHK("warning", 1'b1, q[3])
      bus(1'b1, REG_SEL, 32'h7, q);
      launch(MODE_AUTO2, 1'b0, n);
      `CHK("last station", 1, n)
      bus(1'b0, REG_STATUS, 32'h0, q);
      `CHK("warning clear", 1'b0, q[3])
      home_ok <= 1'b0;
      launch(MODE_AUTO2, 1'b0, n);
      `CHK("no home move", 0, n)
      bus(1'b0, REG_STATUS, 32'h0, q);
      `CHK("home alarm", 1'b1, q[2])
      home_ok <= 1'b1;
      launch(2'h1, 1'b0, n);
      `CHK("other mode", 0, n)
      idx_en <= 1'b0;
      launch(MODE_AUTO2, 1'b0, n);
      `CHK("disabled", 0, n)
      idx_en <= 1'b1;
      two_st <= 1'b0;
      bus(1'b1, REG_SEL, 32'h5E3, q);
      launch(MODE_AUTO2, 1'b0, n);
      `CHK("short station", 8'h03, mst)
      `CHK("short profile", 4'h1, mpf)
      spd_src <= 4'h1;
      bus(1'b1, REG_WORDS, 32'h1234_0004, q);
      launch(MODE_AUTO2, 1'b1, n);
      `CHK("short direct", 1'b0, mdir)
      `CHK("short word move", 1, n)
      `CHK("short word station", 8'h04, mst)
      bus(1'b1, REG_WORDS, 32'h0000_0104, q);
      launch(MODE_AUTO2, 1'b1, n);
      `CHK("wide station", 0, n)
      nrst_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      `CHK("second reset profile", 4'h1, mpf)
      `CHK("reset done flag", 1'b0, isc_if_inst.move_done_flag)
      nrst_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      `CHK("restart in position", 1'b1, isc_if_inst.in_position_flag)
      `CHK("restart request", 1'b0, req)
      print_verdict();
   end
endmodule
`default_nettype wire
